// ==== pkg/anfbi_pkg.sv ====
/*
  Package of the NOR flash bus host: register map, fields, pin bundle,
  state codes and timing counts.
  Assumes a 20 MHz hclk and an asynchronous parallel NOR flash outside.
*/
package anfbi_pkg;
  // ------------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_ADDR  = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_BYTE  = 2;
  localparam int CTRL_OTP   = 3;
  localparam int CTRL_FRST  = 4;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_RDY   = 1;
  localparam int STAT_OTPER = 2;
  localparam int STAT_BSYER = 3;
  localparam logic [3:0]  CFG_RST   = 4'h0;
  localparam logic [24:0] ADDR_RST  = 25'h000_0000;
  localparam logic [15:0] DATA_RST  = 16'h0000;
  // ------------------------------------------------------------------
  // array map and exempt command codes
  // ------------------------------------------------------------------
  localparam logic [7:0]  BLK_FIRST  = 8'h00;
  localparam logic [7:0]  BLK_LAST   = 8'hFF;
  localparam logic [23:0] OTP_TOP    = 24'h00_00FF;
  localparam logic [7:0]  CMD_RESET  = 8'hF0;
  localparam logic [7:0]  CMD_SUSP   = 8'hB0;
  localparam logic [7:0]  CMD_RESUME = 8'h30;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_NS   = 50;
  localparam int T_ACC_NS = 80;
  localparam int T_WP_NS  = 35;
  localparam int SYNC_CYC = 2;
  localparam int RD_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_RAW   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC   = (WP_RAW < 1) ? 1 : WP_RAW;
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        rst_n;
    logic        byte_n;
    logic        edge_block_guard;
    logic [23:0] addr_in;
  } anfbi_ctl_t;
  typedef enum logic [3:0] {
    S_IDLE   = 4'b0001,
    S_SETUP  = 4'b0010,
    S_STROBE = 4'b0100,
    S_HOLD   = 4'b1000
  } anfbi_state_t;
endpackage

// ==== src/anfbi_host.sv ====
/*
  Host controller for an asynchronous parallel NOR flash. Software orders
  single read or write bus cycles over AHB-Lite; the block drives the
  flash strobes, address and data pins and reports status.
  Assumes one flash on the pins and one AHB-Lite master.
*/
// The AHB-Lite register port and the register addresses were decided locally.
// Operation
// - write holds chip select low, output drive high, write strobe low.
// - operations are ordered address/data write cycles to the command register.
// - guard pin high whenever writing first or last block.
// - inside the region only region addresses are presented.
`timescale 1ns/1ps
module anfbi_host
  import anfbi_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output anfbi_ctl_t       fl_ctl,
  output logic [15:0]      dq_o,
  output logic [15:0]      dq_oe,
  input  wire logic [15:0] dq_i,
  input  wire logic        done_flag_pin
);
  // ------------------------------------------------------------------
  // ahb slave
  // ------------------------------------------------------------------
  logic        a_vld_q, a_wr_q, rd_pend_q, hready_q, start_q;
  logic [7:0]  a_ofs_q;
  logic [31:0] hrdata_q;
  logic [3:0]  cfg_q;
  logic [24:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic        otp_err_q, bsy_err_q;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic        rdy_s1_q, rdy_s2_q;
  anfbi_state_t state_q;
  logic [3:0]  cnt_q;
  logic        op_wr_q;
  anfbi_ctl_t  ctl_q;
  logic [15:0] dq_o_q, dq_oe_q;

  wire        take     = hsel & hready & htrans[1];
  wire        wr_en    = a_vld_q & a_wr_q;
  wire        wr_ctrl  = wr_en & (a_ofs_q == OFS_CTRL);
  wire        wr_stat  = wr_en & (a_ofs_q == OFS_STAT);
  wire        busy     = (state_q != S_IDLE);
  wire        byte_md  = cfg_q[CTRL_BYTE-1];
  wire [3:0]  status   = {bsy_err_q, otp_err_q, rdy_s2_q, busy};
  wire [31:0] rd_mux   =
    (a_ofs_q == OFS_CTRL)  ? {27'h000_0000, cfg_q, 1'b0} :
    (a_ofs_q == OFS_ADDR)  ? {7'h00, addr_q} :
    (a_ofs_q == OFS_WDATA) ? {16'h0000, wdata_q} :
    (a_ofs_q == OFS_RDATA) ? {16'h0000, rdata_q} :
    (a_ofs_q == OFS_STAT)  ? {28'h000_0000, status} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_vld_q   <= 1'b0;
      a_wr_q    <= 1'b0;
      a_ofs_q   <= 8'h00;
      rd_pend_q <= 1'b0;
      hready_q  <= 1'b1;
      hrdata_q  <= 32'h0000_0000;
    end
    else
    begin
      a_vld_q   <= take;
      rd_pend_q <= take & ~hwrite;
      if (take)
      begin
        a_wr_q  <= hwrite;
        a_ofs_q <= haddr[7:0];
      end
      // one wait state so that read data leaves a flop
      hready_q <= ~(take & ~hwrite);
      if (rd_pend_q)
        hrdata_q <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  wire [23:0] pin_addr = byte_md ? addr_q[24:1] : addr_q[23:0];
  wire [7:0]  blk      = pin_addr[23:16];
  wire        edge_blk = (blk == BLK_FIRST) | (blk == BLK_LAST);
  wire        otp_bad  = cfg_q[CTRL_OTP-1] & (pin_addr > OTP_TOP);
  wire        exempt   = (wdata_q[7:0] == CMD_RESET) |
                         (wdata_q[7:0] == CMD_SUSP) |
                         (wdata_q[7:0] == CMD_RESUME);
  wire        bsy_bad  = cfg_q[CTRL_WRITE-1] & ~rdy_s2_q & ~exempt;
  wire        go       = start_q & ~busy & ~cfg_q[CTRL_FRST-1];
  wire        launch   = go & ~otp_bad & ~bsy_bad;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q     <= CFG_RST;
      addr_q    <= ADDR_RST;
      wdata_q   <= DATA_RST;
      start_q   <= 1'b0;
      otp_err_q <= 1'b0;
      bsy_err_q <= 1'b0;
    end
    else
    begin
      start_q <= wr_ctrl & hwdata[CTRL_START];
      if (wr_ctrl)
        cfg_q <= hwdata[CTRL_FRST:CTRL_WRITE];
      if (wr_en && a_ofs_q == OFS_ADDR)
        addr_q <= hwdata[24:0];
      if (wr_en && a_ofs_q == OFS_WDATA)
        wdata_q <= hwdata[15:0];
      // a refusal in the clearing cycle still sets the flag
      otp_err_q <= (go & otp_bad) |
                   (otp_err_q & ~(wr_stat & hwdata[STAT_OTPER]));
      bsy_err_q <= (go & ~otp_bad & bsy_bad) |
                   (bsy_err_q & ~(wr_stat & hwdata[STAT_BSYER]));
    end
  end

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dq_s1_q  <= 16'h0000;
      dq_s2_q  <= 16'h0000;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end
    else
    begin
      dq_s1_q  <= dq_i;
      dq_s2_q  <= dq_s1_q;
      rdy_s1_q <= done_flag_pin;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // flash cycle sequencer
  // ------------------------------------------------------------------
  wire [15:0] wr_oe = byte_md ? 16'h80FF : 16'hFFFF;
  wire [15:0] rd_oe = byte_md ? 16'h8000 : 16'h0000;
  wire [15:0] wr_dq = byte_md ? {addr_q[0], 7'h00, wdata_q[7:0]} : wdata_q;
  wire [15:0] rd_cap = byte_md ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= S_IDLE;
      cnt_q   <= 4'h0;
      op_wr_q <= 1'b0;
      rdata_q <= DATA_RST;
      ctl_q   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0,
                   byte_n: 1'b1, edge_block_guard: 1'b0, addr_in: 24'h00_0000};
      dq_o_q  <= 16'h0000;
      dq_oe_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          // reset and width only change between cycles
          ctl_q.rst_n  <= ~cfg_q[CTRL_FRST-1];
          ctl_q.byte_n <= ~byte_md;
          if (launch)
          begin
            op_wr_q       <= cfg_q[CTRL_WRITE-1];
            ctl_q.ce_n    <= 1'b0;
            ctl_q.addr_in <= pin_addr;
            ctl_q.edge_block_guard <= cfg_q[CTRL_WRITE-1] & edge_blk;
            dq_o_q  <= cfg_q[CTRL_WRITE-1] ? wr_dq : {addr_q[0], 15'h0000};
            dq_oe_q <= cfg_q[CTRL_WRITE-1] ? wr_oe : rd_oe;
            state_q <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          if (op_wr_q)
          begin
            ctl_q.we_n <= 1'b0;
            cnt_q      <= 4'(WP_CYC - 1);
          end
          else
          begin
            ctl_q.oe_n <= 1'b0;
            cnt_q      <= 4'(RD_CYC + SYNC_CYC - 1);
          end
          state_q <= S_STROBE;
        end
        S_STROBE:
        begin
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else
          begin
            ctl_q.we_n <= 1'b1;
            ctl_q.oe_n <= 1'b1;
            if (!op_wr_q)
              rdata_q <= rd_cap;
            state_q <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          // data and address held one cycle past the write strobe
          ctl_q.ce_n <= 1'b1;
          ctl_q.edge_block_guard <= 1'b0;
          dq_oe_q <= 16'h0000;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  assign hreadyout = hready_q;
  assign hrdata    = hrdata_q;
  assign fl_ctl    = ctl_q;
  assign dq_o      = dq_o_q;
  assign dq_oe     = dq_oe_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  localparam int WP_N = WP_CYC;

  property p_wr_strobes;
    @(posedge hclk) disable iff (!hresetn)
    !ctl_q.we_n |-> (!ctl_q.ce_n && ctl_q.oe_n && ctl_q.rst_n);
  endproperty
  a_wr_strobes: assert property (p_wr_strobes)
    else $error("write strobe without proper chip select or reset");

  property p_guard;
    @(posedge hclk) disable iff (!hresetn)
    (!ctl_q.we_n && (ctl_q.addr_in[23:16] == BLK_FIRST ||
     ctl_q.addr_in[23:16] == BLK_LAST)) |-> ctl_q.edge_block_guard;
  endproperty
  a_guard: assert property (p_guard)
    else $error("edge block written with guard low");

  property p_otp;
    @(posedge hclk) disable iff (!hresetn)
    ($rose(!ctl_q.ce_n) && cfg_q[CTRL_OTP-1]) |-> ctl_q.addr_in <= OTP_TOP;
  endproperty
  a_otp: assert property (p_otp)
    else $error("address outside region while region entered");

  property p_busy;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == S_SETUP && op_wr_q) |-> ($past(rdy_s2_q) || $past(exempt));
  endproperty
  a_busy: assert property (p_busy)
    else $error("write issued while flash busy");

  property p_we_width;
    @(posedge hclk) disable iff (!hresetn)
    $fell(ctl_q.we_n) |-> ##WP_N ctl_q.we_n ##1 ctl_q.ce_n;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width or release order wrong");

  property p_addr_stable;
    @(posedge hclk) disable iff (!hresetn)
    (!ctl_q.ce_n && $past(!ctl_q.ce_n)) |-> $stable(ctl_q.addr_in);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved inside a bus cycle");

  property p_byte_float;
    @(posedge hclk) disable iff (!hresetn)
    (!ctl_q.byte_n && !ctl_q.ce_n) |-> (dq_oe_q[14:8] == 7'h00 && dq_oe_q[15]);
  endproperty
  a_byte_float: assert property (p_byte_float)
    else $error("byte mode upper pins driven or low address missing");

  property p_read_cap;
    @(posedge hclk) disable iff (!hresetn)
    $fell(ctl_q.oe_n) |-> (!ctl_q.oe_n && ctl_q.we_n) [*4] ##1 ctl_q.oe_n;
  endproperty
  a_read_cap: assert property (p_read_cap)
    else $error("read strobe length wrong");

  property p_ahb_wait;
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_ahb_wait: assert property (p_ahb_wait)
    else $error("read wait state not exactly one cycle");
endmodule

// ==== bench/anfbi_flash_model.sv ====
/*
  Behavioural NOR flash: word program sequence, busy pin, poll bits.
  Assumes the host drives fl_ctl and dq_o; block erase included, no region logic.
*/
`timescale 1ns/1ps
module anfbi_flash_model
  import anfbi_pkg::*;
(
  input  wire anfbi_ctl_t  fl_ctl,
  input  wire logic [15:0] dq_o,
  input  wire logic [15:0] dq_oe,
  output logic [15:0]      dq_i,
  output logic             done_flag_pin
);
  logic [15:0] mem [logic [23:0]];
  logic [15:0] last = 16'h0000;
  logic [15:0] pd   = 16'h0000;
  logic        tog  = 1'b0;
  int          st   = 0;
  int          wr_n = 0;
  wire  [23:0] a    = fl_ctl.addr_in;
  wire rd = !fl_ctl.ce_n && !fl_ctl.oe_n && fl_ctl.we_n && fl_ctl.rst_n;
  wire edge_blk = a[23:16] == BLK_FIRST || a[23:16] == BLK_LAST;
  initial done_flag_pin = 1'b1;
  function automatic logic [15:0] word(input logic [23:0] x);
    return mem.exists(x) ? mem[x] : 16'hFFFF;
  endfunction
  // ------------------------------------------------------------------
  // read side; released lines show the inverse of the last value
  // ------------------------------------------------------------------
  // rd and a are listed too: they settle a delta after fl_ctl moves
  always @(fl_ctl or tog or wr_n or done_flag_pin or dq_o or rd or a)
  begin
    logic [15:0] v;
    v = done_flag_pin ? word(a) : {pd[15:8], ~pd[7], tog, pd[5:0]};
    if (!fl_ctl.byte_n)
      v = {~last[15:8], dq_o[15] ? v[15:8] : v[7:0]};
    dq_i = rd ? v : ~last;
    if (rd)
      last = v;
  end
  always @(negedge fl_ctl.oe_n) if (!done_flag_pin) tog = ~tog;
  always @(negedge fl_ctl.rst_n) st = 0;
  // ------------------------------------------------------------------
  // command sequence; writes while busy are dropped
  // ------------------------------------------------------------------
  always @(posedge fl_ctl.we_n)
  if (!fl_ctl.ce_n && fl_ctl.rst_n && done_flag_pin)
  begin
    case (st)
      0: st = (a[10:0] == 11'h555 && dq_o[7:0] == 8'hAA) ? 1 : 0;
      1: st = (a[10:0] == 11'h2AA && dq_o[7:0] == 8'h55) ? 2 : 0;
      2: st = (a[10:0] == 11'h555 && dq_o[7:0] == 8'hA0) ? 3 :
              (a[10:0] == 11'h555 && dq_o[7:0] == 8'h80) ? 4 : 0;
      4: st = (a[10:0] == 11'h555 && dq_o[7:0] == 8'hAA) ? 5 : 0;
      5: st = (a[10:0] == 11'h2AA && dq_o[7:0] == 8'h55) ? 6 : 0;
      6:
      begin
        st = 0;
        if (dq_o[7:0] == 8'h30 && (!edge_blk || fl_ctl.edge_block_guard))
        begin
          pd = 16'hFFFF;
          foreach (mem[k])
            if (k[23:16] == a[23:16])
              mem[k] = 16'h0000;
          foreach (mem[k])
            if (k[23:16] == a[23:16])
              mem[k] = 16'hFFFF;
          wr_n++;
          done_flag_pin = 1'b0;
          #3000 done_flag_pin = 1'b1;
        end
      end
      3:
      begin
        st = 0;
        pd = dq_o;
        if (!edge_blk || fl_ctl.edge_block_guard)
          mem[a] = word(a) & dq_o;
        wr_n++;
        done_flag_pin = 1'b0;
        #3000 done_flag_pin = 1'b1;
      end
      default:
        st = 0;
    endcase
  end
endmodule

// ==== bench/anfbi_host_tb_top.sv ====
/*
  Self-checking bench of the flash host: AHB-Lite master tasks, scenarios.
  Assumes anfbi_flash_model on the pins and hready looped from hreadyout.
*/
`timescale 1ns/1ps
module anfbi_host_tb_top;
  import anfbi_pkg::*;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic        hreadyout, hresp, done_flag_pin;
  logic [31:0] hrdata, rd;
  anfbi_ctl_t  fl_ctl;
  logic [15:0] dq_o, dq_oe, dq_i;
  int          num_errors = 0;
  int          num_checks = 0;
  int          ce_cnt = 0;
  always #25 hclk = ~hclk;
  anfbi_host anfbi_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .fl_ctl(fl_ctl), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .done_flag_pin(done_flag_pin));
  anfbi_flash_model anfbi_flash_model_i (.fl_ctl(fl_ctl), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq_i(dq_i), .done_flag_pin(done_flag_pin));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h00_0000, a}; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task fcyc(input logic [24:0] a, input logic [15:0] d, input logic [4:0] c);
    int n;
    ahb(1, OFS_ADDR, {7'h00, a});
    ahb(1, OFS_WDATA, {16'h0000, d});
    ahb(1, OFS_CTRL, {27'h000_0000, c});
    n = 0;
    do begin ahb(0, OFS_STAT, 0); n++; end
    while (rd[STAT_BUSY] !== 1'b0 && n < 50);
    chk("busy_limit", 0, rd[STAT_BUSY]);
  endtask
  task prog(input logic [23:0] a, input logic [15:0] d);
    fcyc(25'h555, 16'h00AA, 5'h03);
    fcyc(25'h2AA, 16'h0055, 5'h03);
    fcyc(25'h555, 16'h00A0, 5'h03);
    fcyc({1'b0, a}, d, 5'h03);
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do begin ahb(0, OFS_STAT, 0); n++; end
    while (rd[STAT_RDY] !== 1'b1 && n < 300);
    chk("rdy_limit", 1, rd[STAT_RDY]);
  endtask
  task rd_word(input logic [24:0] a, input logic [4:0] c);
    fcyc(a, 16'h0000, c);
    ahb(0, OFS_RDATA, 0);
  endtask
  // ------------------------------------------------------------------
  // pin watch
  // ------------------------------------------------------------------
  always @(negedge fl_ctl.ce_n) ce_cnt++;
  always @(posedge hclk) if (hresetn)
  begin
    if (fl_ctl.we_n === 1'b0)
    begin
      chk("guard", fl_ctl.addr_in[23:16] == 8'h00 ||
        fl_ctl.addr_in[23:16] == 8'hFF, fl_ctl.edge_block_guard);
      chk("wr_oe_n", 1, fl_ctl.oe_n);
      chk("wr_dq_oe", fl_ctl.byte_n ? 32'hFFFF : 32'h80FF, dq_oe);
    end
    if (fl_ctl.oe_n === 1'b0)
      chk("rd_dq_oe", fl_ctl.byte_n ? 0 : 32'h8000, dq_oe);
  end
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task t_reset;
    chk("rst_n", 1, fl_ctl.rst_n);
    chk("ce_n", 1, fl_ctl.ce_n);
    chk("hresp", 0, hresp);
    ahb(0, OFS_CTRL, 0);  chk("ctrl", 0, rd);
    ahb(0, OFS_ADDR, 0);  chk("addr", 0, rd);
    ahb(0, OFS_RDATA, 0); chk("rdata", 0, rd);
    ahb(0, OFS_STAT, 0);  chk("stat", 32'h0000_0002, rd);
    ahb(1, 8'h14, 32'hFFFF_FFFF);
    ahb(0, 8'h14, 0);     chk("unmapped", 0, rd);
  endtask
  task t_prog;
    prog(24'h00_0010, 16'h1234);
    wait_rdy;
    rd_word(25'h000_0010, 5'h01); chk("blk0", 32'h1234, rd);
    prog(24'hFF_0020, 16'hA5C3);
    wait_rdy;
    rd_word(25'h0FF_0020, 5'h01); chk("blk255", 32'hA5C3, rd);
    fcyc(25'h555, 16'h00AA, 5'h03);
    fcyc(25'h2AA, 16'h0077, 5'h03);
    fcyc(25'h555, 16'h00A0, 5'h03);
    fcyc(25'h000_0030, 16'h0000, 5'h03);
    rd_word(25'h000_0030, 5'h01); chk("abort", 32'hFFFF, rd);
  endtask
  task t_busy;
    prog(24'h01_0000, 16'h0F0F);
    fcyc(25'h000_0040, 16'h0055, 5'h03);
    ahb(0, OFS_STAT, 0); chk("busy_err", 1, rd[STAT_BSYER]);
    ahb(1, OFS_STAT, 32'h0000_0008);
    fcyc(25'h000_0000, 16'h00F0, 5'h03);
    ahb(0, OFS_STAT, 0); chk("reset_ok", 0, rd[STAT_BSYER]);
    rd_word(25'h001_0000, 5'h01); chk("poll", 1, rd[7]);
    wait_rdy;
    rd_word(25'h001_0000, 5'h01); chk("prog_w", 32'h0F0F, rd);
    fcyc(25'h555, 16'h00AA, 5'h03);
    fcyc(25'h2AA, 16'h0055, 5'h03);
    fcyc(25'h555, 16'h0080, 5'h03);
    fcyc(25'h555, 16'h00AA, 5'h03);
    fcyc(25'h2AA, 16'h0055, 5'h03);
    fcyc(25'h001_0000, 16'h0030, 5'h03);
    wait_rdy;
    rd_word(25'h001_0000, 5'h01); chk("erase", 32'hFFFF, rd);
  endtask
  task t_frst;
    int c;
    c = ce_cnt;
    ahb(1, OFS_CTRL, 32'h0000_0010);
    repeat (2) @(posedge hclk);
    chk("frst_pin", 0, fl_ctl.rst_n);
    ahb(1, OFS_CTRL, 32'h0000_0013);
    repeat (8) @(posedge hclk);
    chk("frst_hold", c, ce_cnt);
    ahb(1, OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk("frst_off", 1, fl_ctl.rst_n);
  endtask
  task t_byte;
    rd_word(25'h1FE_0041, 5'h05); chk("byte_hi", 32'hA5, rd);
    rd_word(25'h1FE_0040, 5'h05); chk("byte_lo", 32'hC3, rd);
  endtask
  task t_otp;
    int c;
    rd_word(25'h000_0080, 5'h09);
    ahb(0, OFS_STAT, 0); chk("otp_ok", 0, rd[STAT_OTPER]);
    c = ce_cnt;
    rd_word(25'h000_0100, 5'h09);
    chk("otp_pins", c, ce_cnt);
    ahb(0, OFS_STAT, 0); chk("otp_err", 1, rd[STAT_OTPER]);
    ahb(1, OFS_STAT, 32'h0000_0004);
    ahb(0, OFS_STAT, 0); chk("otp_clr", 0, rd[STAT_OTPER]);
  endtask
  task end_sim;
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    num_errors++;
    end_sim;
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_reset;
    t_prog;
    t_busy;
    t_byte;
    t_otp;
    t_frst;
    end_sim;
  end
endmodule
